// *** verilog/sbs_consts.vh ***
// Shared constants of the synchronous burst SRAM control core.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH

// ============================================================
// Decoded cycle operations.
`define SBS_OP_W 2
`define SBS_OP_DESELECT 2'h0
`define SBS_OP_BEGIN 2'h1
`define SBS_OP_CONTINUE 2'h2
`define SBS_OP_SUSPEND 2'h3

// ============================================================
// Burst counter field and values.
`define SBS_CNT_W 2
`define SBS_CNT_LSB 0
`define SBS_CNT_MSB 1
`define SBS_CNT_RESET 2'h0
`define SBS_CNT_STEP 2'h1

// ============================================================
// Mode pin levels.
`define SBS_ORDER_LINEAR 1'b0
`define SBS_ORDER_INTERLEAVED 1'b1
`define SBS_FLOW_THROUGH 1'b0
`define SBS_PIPELINED 1'b1

// ============================================================
// Reset values of the drive and write enables and the cycle operation.
`define SBS_OE_N_RESET 1'b1
`define SBS_LANE_WR_RESET 1'b0
`define SBS_OP_RESET 2'h0

`endif

// *** verilog/sbs_core.v ***
// Synchronous control core of a burst SRAM: cycle decode, burst counter,
// byte-lane write decode, flow-through or pipelined read path, sleep.
// Assumes a combinational array outside: it reads o_mem_addr and returns
// i_mem_rdata in the same cycle, and writes lanes flagged in o_mem_wr_lane.
// The data bus wire is resolved outside from o_data_out and o_data_oe_n.
//
// What this block does
// - Low address bits preset the burst counter
// - Order pin low linear, high interleaved
// - Linear order adds one modulo four
// - Interleaved order XORs start with step
// - Both write controls high means read
// - Global write low writes every lane
// - Byte write writes only enabled lanes
// - Reads drive every data lane
// - Writes keep all data lanes released
// - Lanes c and d only when wide
// - Flow-through when low, pipelined otherwise
// - Unconnected mode pins mean default modes
// - Sleep request high enters standby
// - Output enable high disables data drive
// - Deselect uses no address, bus released
// - Processor strobe begins a forced read
// - Controller strobe begins read or write
// - Advance low continues at next address
// - Advance high suspends, repeating current access
// - Write indication follows byte-write decode; here any write control low flags a write, even with no lane enabled
// - Dummy reads advance the counter normally
`timescale 1ns/100ps
`include "sbs_consts.vh"

module sbs_core #(
    parameter ADDR_W = 23,
    parameter LANES = 4,
    parameter LANE_W = 9
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Address and burst control
    input wire [ADDR_W-1:0] i_addr,
    input wire i_chip_enable_n,
    input wire i_processor_address_strobe_n,
    input wire i_controller_address_strobe_n,
    input wire i_burst_step_n,
    // Write controls
    input wire i_global_write_n,
    input wire i_byte_write_n,
    input wire [LANES-1:0] i_lane_write_n,
    // Output enable and mode pins
    input wire i_output_enable_n,
    input wire i_burst_order_select,
    input wire i_flow_through_select,
    input wire i_sleep_request,
    input wire i_drive_strength_select,
    // Data bus pin, split
    input wire [LANES*LANE_W-1:0] i_data_in,
    output wire [LANES*LANE_W-1:0] o_data_out,
    output wire [LANES-1:0] o_data_oe_n,
    // Array side
    output wire [ADDR_W-1:0] o_mem_addr,
    output wire o_mem_rd,
    output wire [LANES-1:0] o_mem_wr_lane,
    output wire [LANES*LANE_W-1:0] o_mem_wdata,
    input wire [LANES*LANE_W-1:0] i_mem_rdata,
    // Status
    output wire [`SBS_OP_W-1:0] o_cycle_op,
    output wire o_cycle_write,
    output wire o_standby,
    output wire o_high_drive
);

    localparam DW = LANES * LANE_W;
    localparam HI_W = ADDR_W - `SBS_CNT_W;

    // ============================================================
    // Cycle decode.
    wire desel_w;
    wire begin_w;
    wire force_rd_w;
    wire advance_w;
    wire access_w;
    wire wr_dec_w;
    wire is_wr_w;
    wire is_rd_w;
    reg [`SBS_OP_W-1:0] op_w;

    // Sleep turns every cycle into a non-access; the pin is sampled here.
    assign desel_w = i_chip_enable_n & ~i_controller_address_strobe_n;
    assign force_rd_w = ~i_chip_enable_n & ~i_processor_address_strobe_n;
    assign begin_w = ~i_chip_enable_n &
        (~i_processor_address_strobe_n | ~i_controller_address_strobe_n);
    assign advance_w = ~i_burst_step_n;
    assign access_w = ~i_sleep_request & ~desel_w;

    // Either write control low calls for a write; both high is a read.
    assign wr_dec_w = ~i_global_write_n | ~i_byte_write_n;
    assign is_wr_w = access_w & ~force_rd_w & wr_dec_w;
    assign is_rd_w = access_w & ~is_wr_w;

    always @* begin
        if (i_sleep_request | desel_w) begin
            op_w = `SBS_OP_DESELECT;
        end else if (begin_w) begin
            op_w = `SBS_OP_BEGIN;
        end else if (advance_w) begin
            op_w = `SBS_OP_CONTINUE;
        end else begin
            op_w = `SBS_OP_SUSPEND;
        end
    end

    // ============================================================
    // Burst counter.
    reg [`SBS_CNT_W-1:0] start_q;
    reg [`SBS_CNT_W-1:0] start_d;
    reg [`SBS_CNT_W-1:0] step_q;
    reg [`SBS_CNT_W-1:0] step_d;
    reg [HI_W-1:0] hi_q;
    reg [HI_W-1:0] hi_d;
    reg [`SBS_CNT_W-1:0] lo_w;

    // The counter steps on read and write alike, and never looks at the
    // output enable, so a dummy read moves it exactly as a real one.
    always @* begin
        start_d = start_q;
        step_d = step_q;
        hi_d = hi_q;
        case (op_w)
            `SBS_OP_BEGIN: begin
                start_d = i_addr[`SBS_CNT_MSB:`SBS_CNT_LSB];
                step_d = `SBS_CNT_RESET;
                hi_d = i_addr[ADDR_W-1:`SBS_CNT_W];
            end
            `SBS_OP_CONTINUE: begin
                step_d = step_q + `SBS_CNT_STEP;
            end
            `SBS_OP_SUSPEND: begin
                step_d = step_q;
            end
            default: begin
                step_d = step_q;
            end
        endcase
    end

    // Two-bit arithmetic wraps by itself, so the fifth access is the start.
    always @* begin
        if (i_burst_order_select == `SBS_ORDER_INTERLEAVED) begin
            lo_w = start_d ^ step_d;
        end else begin
            lo_w = start_d + step_d;
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            start_q <= `SBS_CNT_RESET;
            step_q <= `SBS_CNT_RESET;
            hi_q <= {HI_W{1'b0}};
        end else begin
            start_q <= start_d;
            step_q <= step_d;
            hi_q <= hi_d;
        end
    end

    // ============================================================
    // Array request.
    reg [ADDR_W-1:0] mem_addr_q;
    reg mem_rd_q;
    reg [DW-1:0] mem_wdata_q;
    reg [`SBS_OP_W-1:0] op_q;
    reg cycle_wr_q;
    reg standby_q;
    reg high_drive_q;

    // A deselect keeps the last address; it is not used because no strobe goes out.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mem_addr_q <= {ADDR_W{1'b0}};
            mem_rd_q <= 1'b0;
            mem_wdata_q <= {DW{1'b0}};
            op_q <= `SBS_OP_RESET;
            cycle_wr_q <= 1'b0;
            standby_q <= 1'b0;
            high_drive_q <= 1'b0;
        end else begin
            if (access_w) begin
                mem_addr_q <= {hi_d, lo_w};
            end
            mem_rd_q <= is_rd_w;
            if (is_wr_w) begin
                mem_wdata_q <= i_data_in;
            end
            op_q <= op_w;
            cycle_wr_q <= is_wr_w;
            standby_q <= i_sleep_request;
            high_drive_q <= ~i_drive_strength_select;
        end
    end

    // ============================================================
    // Read path.
    reg [DW-1:0] stage_q;
    reg stage_v_q;
    reg [DW-1:0] out_q;
    wire pipe_w;
    wire [DW-1:0] out_d;
    wire out_v_w;
    wire drive_w;

    // High is the default and also the pulled-up level of a floating pin.
    assign pipe_w = (i_flow_through_select == `SBS_PIPELINED);
    assign out_d = pipe_w ? stage_q : i_mem_rdata;
    assign out_v_w = pipe_w ? stage_v_q : mem_rd_q;

    // Output enable is sampled, so release lags its pin by one cycle. The
    // bus is also released in any write cycle, even with a read in flight.
    assign drive_w = out_v_w & ~i_output_enable_n & ~is_wr_w & ~i_sleep_request;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stage_q <= {DW{1'b0}};
            stage_v_q <= 1'b0;
            out_q <= {DW{1'b0}};
        end else begin
            if (mem_rd_q) begin
                stage_q <= i_mem_rdata;
            end
            stage_v_q <= mem_rd_q;
            if (out_v_w) begin
                out_q <= out_d;
            end
        end
    end

    // ============================================================
    // Per-lane write and drive enables.
    reg [LANES-1:0] wr_lane_q;
    reg [LANES-1:0] oe_n_q;

    // LANES = 2 gives the narrow part, 4 adds lanes c and d.
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            wire lane_wr_w;
            // Global write overrides lane enables; byte write uses them.
            assign lane_wr_w = is_wr_w &
                (~i_global_write_n | (~i_byte_write_n & ~i_lane_write_n[g]));
            always @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    wr_lane_q[g] <= `SBS_LANE_WR_RESET;
                    oe_n_q[g] <= `SBS_OE_N_RESET;
                end else begin
                    wr_lane_q[g] <= lane_wr_w;
                    oe_n_q[g] <= ~drive_w;
                end
            end
        end
    endgenerate

    // ============================================================
    // Outputs.
    assign o_data_out = out_q;
    assign o_data_oe_n = oe_n_q;
    assign o_mem_addr = mem_addr_q;
    assign o_mem_rd = mem_rd_q;
    assign o_mem_wr_lane = wr_lane_q;
    assign o_mem_wdata = mem_wdata_q;
    assign o_cycle_op = op_q;
    assign o_cycle_write = cycle_wr_q;
    assign o_standby = standby_q;
    assign o_high_drive = high_drive_q;

endmodule

// *** tb/sbs_array_model.sv ***
// Array model beside the core: combinational read, lane writes on the clock.
// Assumes registered requests from the core; only 16 words are kept.
`timescale 1ns/100ps
module sbs_array_model (
    // Core side
    input wire i_clk,
    input wire [3:0] i_addr,
    input wire i_rd,
    input wire [3:0] i_wr_lane,
    input wire [35:0] i_wdata,
    output wire [35:0] o_rdata
);
    logic [35:0] mem_q [16];
    // Inverted data when idle, so a stale word never passes for an answer.
    assign o_rdata = i_rd ? mem_q[i_addr] : ~mem_q[i_addr];
    always @(posedge i_clk) begin
        for (int g = 0; g < 4; g++) begin
            if (i_wr_lane[g]) mem_q[i_addr][g*9 +: 9] <= i_wdata[g*9 +: 9];
        end
    end
endmodule

// *** tb/sbs_core_properties.sv ***
// Checker bound to the ports of the burst SRAM control core.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`include "sbs_consts.vh"
module sbs_core_properties #(parameter ADDR_W = 23, parameter LANES = 4, parameter LANE_W = 9) (
    // Watched ports
    input wire i_clk,
    input wire i_arst_n,
    input wire i_chip_enable_n,
    input wire i_processor_address_strobe_n,
    input wire i_controller_address_strobe_n,
    input wire i_global_write_n,
    input wire i_byte_write_n,
    input wire [LANES-1:0] i_lane_write_n,
    input wire i_output_enable_n,
    input wire i_burst_order_select,
    input wire i_sleep_request,
    input wire [LANES-1:0] o_data_oe_n,
    input wire [ADDR_W-1:0] o_mem_addr,
    input wire o_mem_rd,
    input wire [LANES-1:0] o_mem_wr_lane,
    input wire [`SBS_OP_W-1:0] o_cycle_op,
    input wire o_cycle_write
);
    // ==========
    // Decoded requests.
    wire awake = !i_sleep_request && !i_chip_enable_n;
    wire w_desel = i_chip_enable_n && !i_controller_address_strobe_n;
    wire w_processor_address_strobe = awake && !i_processor_address_strobe_n;
    wire w_bw = awake && i_processor_address_strobe_n && !i_controller_address_strobe_n &&
        i_global_write_n && !i_byte_write_n;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_desel_idle: assert property ($past(w_desel) |-> o_cycle_op == 0 && !o_mem_rd &&
        o_mem_wr_lane == 0) else $error("deselect accessed");
    a_strobe_read: assert property ($past(w_processor_address_strobe) |-> o_mem_rd && o_mem_wr_lane == 0 &&
        o_cycle_op == `SBS_OP_BEGIN) else $error("bad forced read");
    a_byte_lanes: assert property ($past(w_bw) |-> o_cycle_write &&
        o_mem_wr_lane == ~$past(i_lane_write_n)) else $error("bad lanes");
    a_linear_step: assert property (
        o_cycle_op == `SBS_OP_CONTINUE && $past(o_cycle_op) != 0 &&
        !$past(i_burst_order_select) |-> o_mem_addr[1:0] == $past(o_mem_addr[1:0]) + 2'h1)
        else $error("bad linear step");
    a_suspend_hold: assert property (
        o_cycle_op == `SBS_OP_SUSPEND && $past(o_cycle_op) != 0 |->
        $stable(o_mem_addr)) else $error("suspend moved");
    a_write_float: assert property (o_cycle_write |-> &o_data_oe_n)
        else $error("driven on write");
    a_oe_release: assert property ($past(i_output_enable_n) |-> &o_data_oe_n)
        else $error("driven with oe high");
    a_sleep_idle: assert property ($past(i_sleep_request) |-> o_cycle_op == 0 && !o_mem_rd &&
        o_mem_wr_lane == 0) else $error("access in sleep");
endmodule
bind sbs_core sbs_core_properties #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) i_props (
    .i_clk, .i_arst_n, .i_chip_enable_n, .i_processor_address_strobe_n,
    .i_controller_address_strobe_n, .i_global_write_n, .i_byte_write_n, .i_lane_write_n,
    .i_output_enable_n, .i_burst_order_select, .i_sleep_request, .o_data_oe_n, .o_mem_addr,
    .o_mem_rd, .o_mem_wr_lane, .o_cycle_op, .o_cycle_write);

// *** tb/tb.sv ***
// Self-checking bench of the burst SRAM control core with an array model.
// Assumes the core's default widths and a 50 ns clock.
`timescale 1ns/100ps
`include "sbs_consts.vh"
module tb;
    typedef struct packed {logic [5:0] c; logic [3:0] l; logic [3:0] w; logic [1:0] op;
        logic rd; logic cw;} sbs_row_t;
    logic i_clk = 0, i_arst_n = 0, ord = 0, ft = 1, slp = 0, ds = 1, oe_n = 1;
    logic [5:0] ctl = 6'h37;
    logic [3:0] ln = 4'hf;
    logic [22:0] ad = 0;
    wire [35:0] dout, mwd, mrd;
    wire [22:0] ma;
    wire [3:0] doe_n, wl;
    wire [1:0] op;
    wire rd, cw, stb, hd;
    int err_count = 0, tests_run = 0;
    sbs_row_t rows [8];
    sbs_core i_sbs_core (.i_clk, .i_arst_n, .i_addr(ad), .i_chip_enable_n(ctl[5]),
        .i_processor_address_strobe_n(ctl[4]), .i_controller_address_strobe_n(ctl[3]),
        .i_burst_step_n(ctl[2]), .i_global_write_n(ctl[1]), .i_byte_write_n(ctl[0]),
        .i_lane_write_n(ln), .i_output_enable_n(oe_n), .i_burst_order_select(ord),
        .i_flow_through_select(ft), .i_sleep_request(slp), .i_drive_strength_select(ds),
        .i_data_in(36'h9_1234_5678), .o_data_out(dout), .o_data_oe_n(doe_n), .o_mem_addr(ma),
        .o_mem_rd(rd), .o_mem_wr_lane(wl), .o_mem_wdata(mwd), .i_mem_rdata(mrd),
        .o_cycle_op(op), .o_cycle_write(cw), .o_standby(stb), .o_high_drive(hd));
    sbs_array_model i_sbs_array_model (.i_clk, .i_addr(ma[3:0]), .i_rd(rd), .i_wr_lane(wl),
        .i_wdata(mwd), .o_rdata(mrd));
    always #25 i_clk = ~i_clk;
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    // Results of a request show at the falling edge after the next request.
    task automatic go(input logic [5:0] c, input logic [3:0] l, input logic [22:0] a);
        @(posedge i_clk);
        ctl <= c;
        ln <= l;
        ad <= a;
        @(negedge i_clk);
    endtask
    task automatic stop_test;
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        stop_test;
    end
    initial begin
        rows = '{{6'h37, 4'hf, 4'h0, 2'h0, 1'h0, 1'h0}, {6'h0d, 4'h0, 4'h0, 2'h1, 1'h1, 1'h0},
            {6'h15, 4'hf, 4'hf, 2'h1, 1'h0, 1'h1}, {6'h16, 4'ha, 4'h5, 2'h1, 1'h0, 1'h1},
            {6'h16, 4'hf, 4'h0, 2'h1, 1'h0, 1'h1}, {6'h17, 4'h0, 4'h0, 2'h1, 1'h1, 1'h0},
            {6'h3b, 4'h0, 4'h0, 2'h2, 1'h1, 1'h0}, {6'h3d, 4'hf, 4'hf, 2'h3, 1'h0, 1'h1}};
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        foreach (rows[i]) begin
            go(rows[i].c, rows[i].l, 23'h40 + 23'(i));
            go(6'h37, 4'hf, 23'h0);
            chk(op, rows[i].op);
            chk(wl, rows[i].w);
            chk({rd, cw}, {rows[i].rd, rows[i].cw});
            if (rows[i].op == `SBS_OP_BEGIN) chk(ma, 23'h40 + 23'(i));
        end
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        @(negedge i_clk);
        chk({doe_n, op, wl, rd}, {4'hf, 2'h0, 4'h0, 1'h0});
        for (int o = 0; o < 2; o++) begin
            @(posedge i_clk);
            i_arst_n <= 1'b1;
            ord <= o[0];
            go(6'h17, 4'h0, 23'h1236);
            for (int k = 1; k < 7; k++) begin
                int s;
                s = (k > 5) ? 4 : k - 1;
                go(k < 5 ? 6'h3b : (k == 5 ? 6'h3f : 6'h37), 4'h0, 23'h0);
                chk(ma, {21'h48d, o ? 2'h2 ^ s[1:0] : 2'h2 + s[1:0]});
                chk(doe_n, 4'hf);
            end
        end
        for (int f = 0; f < 2; f++) begin
            @(posedge i_clk);
            ft <= f[0];
            oe_n <= 1'b0;
            go(6'h15, 4'hf, 23'h5);
            go(6'h0d, 4'h0, 23'h5);
            chk(doe_n, 4'hf);
            go(6'h3f, 4'h0, 23'h0);
            for (int k = 1; k < 4; k++) begin
                @(negedge i_clk);
                if (k == 1 + f) chk({doe_n, dout}, {4'h0, 36'h9_1234_5678});
                else if (k < 1 + f) chk(doe_n, 4'hf);
            end
            go(6'h37, 4'hf, 23'h0);
        end
        @(posedge i_clk);
        slp <= 1'b1;
        ds <= 1'b0;
        go(6'h15, 4'hf, 23'h6);
        go(6'h37, 4'hf, 23'h0);
        chk({stb, hd, op, wl}, {2'h3, 2'h0, 4'h0});
        stop_test;
    end
endmodule
